// ===== rtl/ssr_pkg.sv
// Purpose: shared constants and carriers for the status reporting block
// Assumes: one instrument clock, registers reached through a local port
// Notes: part and register selectors are small codes on the access port
package ssr_pkg;
	localparam int SSR_W = 16; // width of every register part
	localparam int SSR_MSB = 15; // top bit, always reads zero
	localparam int SSR_CASCADE_BIT = 0; // lower register summary lands here
	localparam int SSR_NREG = 4; // lower registers in the hierarchy
	// status byte bit positions
	localparam int SSR_SB_DEV = 1;
	localparam int SSR_SB_ERRQ = 2;
	localparam int SSR_SB_QUES = 3;
	localparam int SSR_SB_MSG = 4;
	localparam int SSR_SB_STD = 5;
	localparam int SSR_SB_MSS = 6;
	localparam int SSR_SB_OPER = 7;
	// reset values
	localparam logic [15:0] SSR_RISE_RST = 16'h7FFF;
	localparam logic [15:0] SSR_FALL_RST = 16'h0000;
	localparam logic [15:0] SSR_MASK_RST = 16'h0000;
	localparam logic [7:0] SSR_REQ_MASK_RST = 8'h00;
	localparam logic [7:0] SSR_STD_MASK_RST = 8'h00;
	// register selectors on the access port
	localparam logic [2:0] SSR_REG_DEV = 3'h0;
	localparam logic [2:0] SSR_REG_QUES = 3'h1;
	localparam logic [2:0] SSR_REG_OPER = 3'h2;
	localparam logic [2:0] SSR_REG_QEXT = 3'h3;
	localparam logic [2:0] SSR_REG_TOP = 3'h4;
	localparam logic [2:0] SSR_REG_STD = 3'h5;

	// part selectors
	typedef enum logic [2:0] {
		SSR_PART_COND = 3'b000,
		SSR_PART_RISE = 3'b001,
		SSR_PART_FALL = 3'b010,
		SSR_PART_EVENT = 3'b011,
		SSR_PART_MASK = 3'b100
	} ssr_part_e;

	// one register access request
	typedef struct packed {
		logic rd; // read strobe
		logic wr; // write strobe
		logic [2:0] sel; // register selector
		ssr_part_e part; // part selector
		logic [15:0] wdata; // write data
	} ssr_req_s;
endpackage

// ===== rtl/ssr_status_hier.sv
// Purpose: status register hierarchy with summary byte and service request
// Assumes: inputs synchronous to clk_in; one access per cycle at most
// Notes: read data and service request are registered outputs
`timescale 1ns/100ps

// Behaviour
// - five 16-bit parts, shared bit numbering
// - bit 15 of every part reads zero
// - condition part follows live inputs continuously
// - condition read-only, no clear, read harmless
// - rising edge sets event if rise filter
// - falling edge sets event if fall filter
// - filters read and write freely
// - event bits latch until next read
// - event read-only, read clears it
// - sum is OR of event AND mask
// - enable mask freely read and written
// - sums route into higher condition bits
// - bit 6 when any enabled bit set
// - request mask enables summary byte bits
// - service request on bit 6 rising
// - controller reads byte, writes request mask
// - bit 1 is device register summary
// - bit 2 while error queue non-empty
// - bit 3 is questionable register summary
// - bit 4 while output message waiting
// - bit 5 is enabled standard event summary
// - bit 7 is operation register summary
// - questionable bit 0 carries extension summary
module ssr_status_hier (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire ssr_pkg::ssr_req_s req_in,
	input wire logic [15:0] dev_cond_in,
	input wire logic [15:0] ques_cond_in,
	input wire logic [15:0] oper_cond_in,
	input wire logic [15:0] qext_cond_in,
	input wire logic [7:0] std_event_set_in,
	input wire logic error_queue_busy_in,
	input wire logic output_message_waiting_in,
	output logic [15:0] rdata_out,
	output logic rvalid_out,
	output logic srq_out
);
	import ssr_pkg::*;

	logic [SSR_W-1:0] cond_live [SSR_NREG]; // live condition per register
	logic [SSR_W-1:0] cond_prev [SSR_NREG]; // last sampled condition
	logic [SSR_W-1:0] rise_filter [SSR_NREG];
	logic [SSR_W-1:0] fall_filter [SSR_NREG];
	logic [SSR_W-1:0] latched_events [SSR_NREG];
	logic [SSR_W-1:0] event_mask [SSR_NREG];
	logic [SSR_NREG-1:0] sum_bit; // per-register summary
	logic [7:0] std_event_register; // standard events, cleared on read
	logic [7:0] std_event_mask;
	logic [7:0] request_mask;
	logic [7:0] top_summary_byte; // live status byte
	logic std_event_summary;
	logic master_summary;
	logic mss_prev; // last master summary for edge detection
	logic [15:0] next_rdata;
	logic [SSR_NREG-1:0] ev_read; // event part read this cycle
	logic [SSR_NREG-1:0] wr_sel; // register hit by a write
	logic [SSR_NREG-1:0] rd_sel;

	// condition parts: level inputs with the lower summary spliced in;
	// the extension register cascades into questionable bit 0
	always_comb begin
		cond_live[0] = {1'b0, dev_cond_in[14:0]};
		cond_live[1] = {1'b0, ques_cond_in[14:1], sum_bit[3]};
		cond_live[2] = {1'b0, oper_cond_in[14:0]};
		cond_live[3] = {1'b0, qext_cond_in[14:0]};
	end

	// decode which register a request targets
	always_comb begin
		for (int i = 0; i < SSR_NREG; i++) begin
			wr_sel[i] = ce_in && req_in.wr && (req_in.sel == 3'(i));
			rd_sel[i] = ce_in && req_in.rd && (req_in.sel == 3'(i));
			ev_read[i] = rd_sel[i] && (req_in.part == SSR_PART_EVENT);
		end
	end

	// sum bits; bit 15 never contributes since its event stays zero
	always_comb begin
		for (int i = 0; i < SSR_NREG; i++) begin
			sum_bit[i] = |(latched_events[i] & event_mask[i]);
		end
	end

	// edge memory of each condition part
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < SSR_NREG; i++) cond_prev[i] <= 16'h0000;
		end else if (ce_in) begin
			for (int i = 0; i < SSR_NREG; i++) cond_prev[i] <= cond_live[i];
		end
	end

	// event latches: filtered edges set, a read clears, the set wins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < SSR_NREG; i++) latched_events[i] <= 16'h0000;
		end else if (ce_in) begin
			for (int i = 0; i < SSR_NREG; i++) begin
				latched_events[i] <= ((ev_read[i] ? 16'h0000
					: latched_events[i])
					| (cond_live[i] & ~cond_prev[i] & rise_filter[i])
					| (~cond_live[i] & cond_prev[i] & fall_filter[i]))
					& 16'h7FFF;
			end
		end
	end

	// filter and mask parts; condition and event writes are dropped
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < SSR_NREG; i++) begin
				rise_filter[i] <= SSR_RISE_RST;
				fall_filter[i] <= SSR_FALL_RST;
				event_mask[i] <= SSR_MASK_RST;
			end
		end else begin
			for (int i = 0; i < SSR_NREG; i++) begin
				if (wr_sel[i]) begin
					case (req_in.part)
						SSR_PART_RISE: rise_filter[i] <= {1'b0, req_in.wdata[14:0]};
						SSR_PART_FALL: fall_filter[i] <= {1'b0, req_in.wdata[14:0]};
						SSR_PART_MASK: event_mask[i] <= {1'b0, req_in.wdata[14:0]};
						default: begin
							// condition and event parts ignore writes
						end
					endcase
				end
			end
		end
	end

	// standard event register and its mask
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			std_event_register <= 8'h00;
			std_event_mask <= SSR_STD_MASK_RST;
		end else if (ce_in) begin
			std_event_register <= ((req_in.rd && req_in.sel == SSR_REG_STD
				&& req_in.part == SSR_PART_EVENT) ? 8'h00 : std_event_register)
				| std_event_set_in; // set beats the read-clear
			if (req_in.wr && req_in.sel == SSR_REG_STD
				&& req_in.part == SSR_PART_MASK)
				std_event_mask <= req_in.wdata[7:0];
		end
	end

	assign std_event_summary = |(std_event_register & std_event_mask);

	// request mask; bit 6 is held zero as it cannot enable itself
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			request_mask <= SSR_REQ_MASK_RST;
		end else if (ce_in && req_in.wr && req_in.sel == SSR_REG_TOP
			&& req_in.part == SSR_PART_MASK) begin
			request_mask <= req_in.wdata[7:0] & 8'hBF;
		end
	end

	// status byte assembled from the summaries of the lower levels
	always_comb begin
		top_summary_byte = 8'h00;
		top_summary_byte[SSR_SB_DEV] = sum_bit[0];
		top_summary_byte[SSR_SB_ERRQ] = error_queue_busy_in;
		top_summary_byte[SSR_SB_QUES] = sum_bit[1];
		top_summary_byte[SSR_SB_MSG] = output_message_waiting_in;
		top_summary_byte[SSR_SB_STD] = std_event_summary;
		top_summary_byte[SSR_SB_OPER] = sum_bit[2];
		master_summary = |(top_summary_byte & request_mask);
		top_summary_byte[SSR_SB_MSS] = master_summary;
	end

	// service request: one-cycle pulse on master summary rising;
	// the error bit follows the queue busy level, so an entry added to
	// a non-empty queue raises no further request
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mss_prev <= 1'b0;
			srq_out <= 1'b0;
		end else if (ce_in) begin
			mss_prev <= master_summary;
			srq_out <= master_summary && !mss_prev;
		end
	end

	// read mux; reading never disturbs condition, filters or masks
	always_comb begin
		next_rdata = 16'h0000;
		if (req_in.sel == SSR_REG_TOP) begin
			if (req_in.part == SSR_PART_MASK)
				next_rdata = {8'h00, request_mask};
			else
				next_rdata = {8'h00, top_summary_byte};
		end else if (req_in.sel == SSR_REG_STD) begin
			if (req_in.part == SSR_PART_MASK)
				next_rdata = {8'h00, std_event_mask};
			else
				next_rdata = {8'h00, std_event_register};
		end else begin
			for (int i = 0; i < SSR_NREG; i++) begin
				if (req_in.sel == 3'(i)) begin
					case (req_in.part)
						SSR_PART_COND: next_rdata = cond_live[i];
						SSR_PART_RISE: next_rdata = rise_filter[i];
						SSR_PART_FALL: next_rdata = fall_filter[i];
						SSR_PART_EVENT: next_rdata = latched_events[i];
						SSR_PART_MASK: next_rdata = event_mask[i];
						default: next_rdata = 16'h0000;
					endcase
				end
			end
		end
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 16'h0000;
			rvalid_out <= 1'b0;
		end else if (ce_in) begin
			rvalid_out <= req_in.rd;
			if (req_in.rd)
				rdata_out <= next_rdata & 16'h7FFF;
		end
	end

	// assertions
	property p_top_zero;
		@(posedge clk_in) disable iff (!rst_n_in)
			rvalid_out |-> !rdata_out[SSR_MSB];
	endproperty
	a_top_zero: assert property (p_top_zero) else $error("bit 15 set");

	property p_rise_sets;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ce_in && !cond_prev[0][1] && cond_live[0][1] && rise_filter[0][1])
			|=> latched_events[0][1];
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise lost");

	property p_fall_sets;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ce_in && cond_prev[2][3] && !cond_live[2][3] && fall_filter[2][3])
			|=> latched_events[2][3];
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall lost");

	property p_no_unfiltered;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ce_in && !latched_events[0][2] && cond_live[0][2] == cond_prev[0][2])
			|=> !latched_events[0][2];
	endproperty
	a_no_unfiltered: assert property (p_no_unfiltered) else $error("spurious event");

	property p_read_clears;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ev_read[1] && cond_live[1] == cond_prev[1])
			|=> latched_events[1] == 16'h0000;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("no clear");

	property p_sum;
		@(posedge clk_in) disable iff (!rst_n_in)
			top_summary_byte[SSR_SB_OPER] == |(latched_events[2] & event_mask[2]);
	endproperty
	a_sum: assert property (p_sum) else $error("sum wrong");

	property p_mss;
		@(posedge clk_in) disable iff (!rst_n_in)
			top_summary_byte[SSR_SB_MSS] == |(top_summary_byte & request_mask & 8'hBF);
	endproperty
	a_mss: assert property (p_mss) else $error("mss wrong");

	sequence s_mss_rise;
		ce_in && !master_summary ##1 ce_in && master_summary;
	endsequence
	property p_srq;
		@(posedge clk_in) disable iff (!rst_n_in)
			s_mss_rise |=> srq_out;
	endproperty
	a_srq: assert property (p_srq) else $error("no request");

	property p_cascade;
		@(posedge clk_in) disable iff (!rst_n_in)
			cond_live[1][SSR_CASCADE_BIT] == sum_bit[3];
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade broken");

	// every accepted read is answered exactly one edge later
	property p_rvalid;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ce_in && req_in.rd) |=> rvalid_out;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read unanswered");

	// no answer appears without a read, so the controller never double counts
	property p_no_rvalid;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ce_in && !req_in.rd) |=> !rvalid_out;
	endproperty
	a_no_rvalid: assert property (p_no_rvalid) else $error("stray answer");

	// the condition part is a pure view of the live inputs
	property p_cond_follow;
		@(posedge clk_in) disable iff (!rst_n_in)
			cond_live[2] == {1'b0, oper_cond_in[14:0]};
	endproperty
	a_cond_follow: assert property (p_cond_follow) else $error("cond stale");

	// a condition read returns the level present at the strobe
	property p_cond_read;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ce_in && rd_sel[2] && req_in.part == SSR_PART_COND)
			|=> rdata_out == $past(cond_live[2]);
	endproperty
	a_cond_read: assert property (p_cond_read) else $error("cond read");

	// filters only move on a write aimed at them
	property p_rise_keep;
		@(posedge clk_in) disable iff (!rst_n_in)
			!wr_sel[0] |=> $stable(rise_filter[0]);
	endproperty
	a_rise_keep: assert property (p_rise_keep) else $error("rise moved");

	property p_fall_keep;
		@(posedge clk_in) disable iff (!rst_n_in)
			!wr_sel[1] |=> $stable(fall_filter[1]);
	endproperty
	a_fall_keep: assert property (p_fall_keep) else $error("fall moved");

	// enable mask keeps its value across reads and foreign writes
	property p_mask_keep;
		@(posedge clk_in) disable iff (!rst_n_in)
			!wr_sel[2] |=> $stable(event_mask[2]);
	endproperty
	a_mask_keep: assert property (p_mask_keep) else $error("mask moved");

	// a mask write lands with the top bit forced low
	property p_mask_write;
		@(posedge clk_in) disable iff (!rst_n_in)
			(wr_sel[2] && req_in.part == SSR_PART_MASK)
			|=> event_mask[2] == ($past(req_in.wdata) & 16'h7FFF);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write");

	// top bit of every stored part of the extension register stays clear
	property p_msb_zero;
		@(posedge clk_in) disable iff (!rst_n_in)
			!rise_filter[3][SSR_MSB] && !fall_filter[3][SSR_MSB]
			&& !event_mask[3][SSR_MSB] && !latched_events[3][SSR_MSB];
	endproperty
	a_msb_zero: assert property (p_msb_zero) else $error("msb set");

	// a rise arriving with the read-clear must survive it
	property p_set_wins;
		@(posedge clk_in) disable iff (!rst_n_in)
			(ev_read[0] && |(cond_live[0] & ~cond_prev[0] & rise_filter[0]))
			|=> latched_events[0] != 16'h0000;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost");

	// bit 6 of the request mask can never be set
	property p_req_mask6;
		@(posedge clk_in) disable iff (!rst_n_in)
			!request_mask[SSR_SB_MSS];
	endproperty
	a_req_mask6: assert property (p_req_mask6) else $error("mask bit 6");

	// error bit mirrors the queue level
	property p_err_bit;
		@(posedge clk_in) disable iff (!rst_n_in)
			top_summary_byte[SSR_SB_ERRQ] == error_queue_busy_in;
	endproperty
	a_err_bit: assert property (p_err_bit) else $error("error bit");

	// device summary lands in bit 1
	property p_dev_bit;
		@(posedge clk_in) disable iff (!rst_n_in)
			top_summary_byte[SSR_SB_DEV] == |(latched_events[0] & event_mask[0]);
	endproperty
	a_dev_bit: assert property (p_dev_bit) else $error("device bit");

	// a low enable freezes the event store and the request line
	property p_freeze;
		@(posedge clk_in) disable iff (!rst_n_in)
			!ce_in |=> $stable(latched_events[0]) && $stable(srq_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("not frozen");

	// the request is a single-cycle pulse while clocks run
	property p_srq_pulse;
		@(posedge clk_in) disable iff (!rst_n_in)
			(srq_out && ce_in) |=> !srq_out;
	endproperty
	a_srq_pulse: assert property (p_srq_pulse) else $error("long request");
endmodule

// ===== verif/ssr_ctrl_model.sv
// Purpose: remote controller stand-in issuing status register accesses
// Assumes: strobes launched and dropped on rising edges, one cycle each
// Notes: counts every service request pulse the device raises
`timescale 1ns/100ps
module ssr_ctrl_model
	import ssr_pkg::*;
(
	input wire logic clk_in,
	output ssr_pkg::ssr_req_s req_out,
	input wire logic [15:0] rdata_in,
	input wire logic rvalid_in,
	input wire logic srq_in
);
	int n_srq = 0; // service requests seen so far
	initial req_out = '0;
	// srq is a one-cycle pulse, so it must be looked at every edge
	always @(posedge clk_in) begin
		if (srq_in === 1'b1) begin
			n_srq++;
		end
	end
	// mask and filter setting, as the controller does it
	task automatic wr(input logic [2:0] s, input ssr_part_e p,
		input logic [15:0] dat);
		@(posedge clk_in);
		req_out <= '{rd: 1'b0, wr: 1'b1, sel: s, part: p, wdata: dat};
		@(posedge clk_in);
		req_out.wr <= 1'b0;
	endtask
	// query; answer lands one edge after the strobe is launched
	task automatic rd(input logic [2:0] s, input ssr_part_e p,
		output logic [15:0] dat, output logic v);
		@(posedge clk_in);
		req_out <= '{rd: 1'b1, wr: 1'b0, sel: s, part: p, wdata: 16'h0000};
		@(posedge clk_in);
		req_out.rd <= 1'b0;
		#1;
		dat = rdata_in;
		v = rvalid_in;
	endtask
endmodule

// ===== verif/ssr_status_hier_bench.sv
// Purpose: self-checking bench for the status register hierarchy
// Assumes: controller model drives the access port
// Notes: expected events come from a small transition model below
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	n_fail++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ssr_status_hier_bench;
	import ssr_pkg::*;
	logic clk_in = 0, rst_n_in = 0, ce_in = 1, err_q = 0, msg_w = 0;
	logic [15:0] cond [4] = '{default: 16'h0000}; // live levels
	logic [7:0] std_set = 8'h00; // standard event set lines
	ssr_req_s req;
	logic [15:0] rdata, d, r, f, a, b, m;
	logic rvalid, srq, v;
	int n_fail = 0, samples_checked = 0, n0;
	always #25 clk_in = ~clk_in;
	ssr_status_hier i_ssr_status_hier (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .ce_in(ce_in), .req_in(req),
		.dev_cond_in(cond[0]), .ques_cond_in(cond[1]),
		.oper_cond_in(cond[2]), .qext_cond_in(cond[3]),
		.std_event_set_in(std_set), .error_queue_busy_in(err_q),
		.output_message_waiting_in(msg_w), .rdata_out(rdata),
		.rvalid_out(rvalid), .srq_out(srq));
	ssr_ctrl_model i_ssr_ctrl_model (.clk_in(clk_in), .req_out(req),
		.rdata_in(rdata), .rvalid_in(rvalid), .srq_in(srq));
	// filtered transition model; bit 15 never latches
	function automatic logic [15:0] ev(input logic [15:0] o, n, pr, nf);
		return ((~o & n & pr) | (o & ~n & nf)) & 16'h7FFF;
	endfunction
	// read one part and compare it with the expected value
	task automatic rdc(input logic [2:0] s, input ssr_part_e p,
		input logic [15:0] e, input string nm);
		i_ssr_ctrl_model.rd(s, p, d, v);
		`CHK("read valid", 1'b1, v)
		`CHK(nm, e, d)
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#200000;
		n_fail++;
		conclude();
	end
	initial begin
		void'($urandom(42));
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			rdc(3'(s), SSR_PART_RISE, 16'h7FFF, "rise reset");
			rdc(3'(s), SSR_PART_FALL, 16'h0000, "fall reset");
			rdc(3'(s), SSR_PART_MASK, 16'h0000, "mask reset");
		end
		rdc(SSR_REG_TOP, SSR_PART_MASK, 16'h0000, "req mask");
		$display("test reset values done");
		// per register: filters, read-only condition, latch and clear
		for (int s = 0; s < 4; s++) begin
			m = (s == 1) ? 16'h7FFE : 16'h7FFF; // ques bit 0 is cascade
			r = 16'($urandom);
			f = 16'($urandom);
			i_ssr_ctrl_model.wr(3'(s), SSR_PART_RISE, r);
			i_ssr_ctrl_model.wr(3'(s), SSR_PART_FALL, f);
			i_ssr_ctrl_model.wr(3'(s), SSR_PART_MASK, r);
			i_ssr_ctrl_model.wr(3'(s), SSR_PART_COND, 16'hFFFF);
			a = 16'($urandom);
			@(posedge clk_in) cond[s] <= a;
			repeat (3) @(posedge clk_in);
			rdc(3'(s), SSR_PART_COND, a & m, "cond");
			rdc(3'(s), SSR_PART_RISE, r & 16'h7FFF, "rise");
			rdc(3'(s), SSR_PART_FALL, f & 16'h7FFF, "fall");
			rdc(3'(s), SSR_PART_MASK, r & 16'h7FFF, "mask");
			i_ssr_ctrl_model.rd(3'(s), SSR_PART_EVENT, d, v);
			b = 16'($urandom);
			@(posedge clk_in) cond[s] <= b;
			repeat (3) @(posedge clk_in);
			rdc(3'(s), SSR_PART_EVENT, ev(a, b, r, f) & m, "ev");
			rdc(3'(s), SSR_PART_EVENT, 16'h0000, "clr");
			i_ssr_ctrl_model.wr(3'(s), SSR_PART_MASK, 16'h0000);
		end
		$display("test transitions done");
		// quiet all levels, clear events, then climb to a service request
		@(posedge clk_in) cond <= '{default: 16'h0000};
		repeat (3) @(posedge clk_in);
		for (int s = 0; s < 4; s++) begin
			i_ssr_ctrl_model.rd(3'(s), SSR_PART_EVENT, d, v);
		end
		i_ssr_ctrl_model.wr(SSR_REG_DEV, SSR_PART_RISE, 16'h0002);
		i_ssr_ctrl_model.wr(SSR_REG_DEV, SSR_PART_MASK, 16'h0002);
		i_ssr_ctrl_model.wr(SSR_REG_TOP, SSR_PART_MASK, 16'h0042);
		n0 = i_ssr_ctrl_model.n_srq;
		@(posedge clk_in) cond[0] <= 16'h0002;
		repeat (5) @(posedge clk_in);
		`CHK("srq", n0 + 1, i_ssr_ctrl_model.n_srq)
		rdc(SSR_REG_TOP, SSR_PART_COND, 16'h0042, "byte");
		rdc(SSR_REG_DEV, SSR_PART_EVENT, 16'h0002, "dev");
		rdc(SSR_REG_TOP, SSR_PART_COND, 16'h0000, "byte");
		i_ssr_ctrl_model.wr(SSR_REG_TOP, SSR_PART_MASK, 16'h0004);
		@(posedge clk_in) err_q <= 1'b1;
		repeat (5) @(posedge clk_in);
		`CHK("srq", n0 + 2, i_ssr_ctrl_model.n_srq)
		@(posedge clk_in) msg_w <= 1'b1;
		i_ssr_ctrl_model.wr(SSR_REG_STD, SSR_PART_MASK, 16'h0001);
		@(posedge clk_in) std_set <= 8'h01;
		@(posedge clk_in) std_set <= 8'h00;
		i_ssr_ctrl_model.wr(SSR_REG_OPER, SSR_PART_RISE, 16'h0004);
		i_ssr_ctrl_model.wr(SSR_REG_OPER, SSR_PART_MASK, 16'h0004);
		@(posedge clk_in) cond[2] <= 16'h0004;
		repeat (3) @(posedge clk_in);
		rdc(SSR_REG_TOP, SSR_PART_COND, 16'h00F4, "byte");
		$display("test summary chain done");
		// a write issued while the enable is low must be dropped
		@(posedge clk_in) ce_in <= 1'b0;
		i_ssr_ctrl_model.wr(SSR_REG_TOP, SSR_PART_MASK, 16'h0000);
		@(posedge clk_in) ce_in <= 1'b1;
		rdc(SSR_REG_TOP, SSR_PART_MASK, 16'h0004, "frozen mask");
		$display("test clock enable done");
		conclude();
	end
endmodule
